// ---- pwsc_defines.svh ----
`ifndef PWSC_DEFINES_SVH
`define PWSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets (data space) and the I/O space window
// ----------------------------------------------------------------------------
`define PWSC_OFF_SLEEP_MODE_CONTROL   8'h53
`define PWSC_OFF_PROCESSOR_CONTROL    8'h55
`define PWSC_OFF_PERIPH_CLOCK_GATING  8'h64
`define PWSC_OFF_CONVERTER_IN_DISABLE 8'h7e
`define PWSC_OFF_COMPARATOR_IN_DISABLE 8'h7f
`define PWSC_IO_SPACE_BASE            8'h20
`define PWSC_IO_SPACE_LAST            8'h3f

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PWSC_SLEEP_EN_BIT    0
`define PWSC_MODE_LSB        1
`define PWSC_MODE_MSB        3
`define PWSC_VEC_CHG_BIT     0
`define PWSC_VEC_SEL_BIT     1
`define PWSC_PULLUP_DIS_BIT  4
`define PWSC_DET_ARM_BIT     5
`define PWSC_DET_DIS_BIT     6
`define PWSC_GATE_TIMER_TWO_BIT 6

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define PWSC_RST_SLEEP_MODE_CONTROL  8'h00
`define PWSC_RST_PROCESSOR_CONTROL   8'h00
`define PWSC_RST_PERIPH_CLOCK_GATING 8'h00
`define PWSC_RST_CONV_IN_DISABLE     8'h00
`define PWSC_RST_COMP_IN_DISABLE     8'h00
`define PWSC_MASK_SLEEP_MODE_CONTROL  8'h0f
`define PWSC_MASK_PERIPH_CLOCK_GATING 8'hef
`define PWSC_MASK_COMP_IN_DISABLE     8'h03

// ----------------------------------------------------------------------------
// timed sequences, in clock cycles
// ----------------------------------------------------------------------------
`define PWSC_ARM_WINDOW_CYCLES   3'd4
`define PWSC_DET_DELAY_CYCLES    3'd3
`define PWSC_DET_ACTIVE_CYCLES   3'd3
`define PWSC_VEC_WINDOW_CYCLES   3'd4

`endif

// ---- pwsc_pkg.sv ----
package pwsc_pkg;

  typedef enum logic [2:0] {
    PWSC_IDLE          = 3'b000,
    PWSC_NOISE_REDUCE  = 3'b001,
    PWSC_POWER_DOWN    = 3'b010,
    PWSC_POWER_SAVE    = 3'b011,
    PWSC_RSVD_A        = 3'b100,
    PWSC_RSVD_B        = 3'b101,
    PWSC_STANDBY       = 3'b110,
    PWSC_EXT_STANDBY   = 3'b111
  } pwsc_sleep_mode_t;

  typedef enum logic [0:0] {
    PWSC_AWAKE    = 1'b0,
    PWSC_SLEEPING = 1'b1
  } pwsc_state_t;

endpackage

// ---- pwsc_power_sleep_control_regs.sv ----
`timescale 1ns/1ps
`include "pwsc_defines.svh"
// Functional notes
// - sleep mode field bits 3:1 decodes six modes; codes 100 and 101 reserved
// - sleep instruction enters sleep only while sleep enable bit is one
// - input buffers off in sleep modes stopping both I/O and converter clocks
// - pins needed for wake detection keep input buffers on during sleep
// - converter and comparator input disable registers turn off analog pin buffers
// - with debug fuse enabled the main clock runs in every sleep mode
// - an enabled watchdog stays enabled and running in every sleep mode
// - detector sleep disable set only by arm write then set write within four cycles
// - detector sleep disable effective three cycles after set, then cleared after three
// - detector is off in sleep only if sleep executes while disable is effective
// - pull-up disable bit forces all port pull-ups off
// - vector select zero places vectors at flash start, one at boot section
// - vector select changes only by change enable write then write within four cycles
// - interrupts blocked from change enable set until after following instruction, or four cycles
// - automatic interrupt blocking leaves global interrupt enable flag untouched
// - change enable cleared four cycles after write or when vector select written
// - boot lock bits disable interrupts in the section without the vectors
// - gating bit 7 stops two-wire clock; software reinitializes it after
// - gating bit 6 stops timer two only in synchronous mode; resumes frozen state
// - gating bits 5 and 3 stop timers zero and one; they resume after clearing
// - sleep mode and processor control registers reachable at data offset and at offset minus 0x20 in I/O space; the rest only at data offset
// - gated peripheral is frozen and its registers cannot be read or written
// - gating bits 2, 1, 0 stop serial peripheral, serial port, converter
module pwsc_power_sleep_control_regs
  import pwsc_pkg::*;
#(
  parameter int PIN_COUNT = 23
) (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           ioAddr,
  input  wire logic                 ioSpace,
  input  wire logic                 ioWrite,
  input  wire logic                 ioRead,
  input  wire logic [7:0]           ioWrData,
  output logic      [7:0]           ioRdData,
  input  wire logic                 sleepInstr,
  input  wire logic                 wakeEvent,
  input  wire logic                 instrRetire,
  input  wire logic                 execInBoot,
  input  wire logic                 timerTwoAsyncSelect,
  input  wire logic                 debugEnableFuse,
  input  wire logic                 watchdogEnable,
  input  wire logic                 applicationBootLock,
  input  wire logic                 bootloaderBootLock,
  input  wire logic [PIN_COUNT-1:0] wakePinMask,
  output logic                      sleeping,
  output pwsc_sleep_mode_t          activeSleepMode,
  output logic                      ioClkRun,
  output logic                      adcClkRun,
  output logic                      mainClkRun,
  output logic                      watchdogRun,
  output logic                      brownoutDetectorOff,
  output logic                      detectorDisableEffective,
  output logic                      pullupDisable,
  output logic                      vectorSelect,
  output logic                      irqBlock,
  output logic [7:0]                periphClkEn,
  output logic                      timerTwoClkEn,
  output logic [PIN_COUNT-1:0]      pinInBufEn,
  output logic [7:0]                convInBufEn,
  output logic [1:0]                compInBufEn
);

  // --------------------------------------------------------------------------
  // pin synchronisers for static strap levels
  // --------------------------------------------------------------------------
  logic [3:0] strapMeta;
  logic [3:0] strapSync;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta <= 4'h0;
      strapSync <= 4'h0;
    end else begin
      strapMeta <= {debugEnableFuse, watchdogEnable, applicationBootLock, bootloaderBootLock};
      strapSync <= strapMeta;
    end
  end
  logic debugOn, wdogOn, appLock, bootLock;
  assign {debugOn, wdogOn, appLock, bootLock} = strapSync;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  logic [7:0] effAddr;
  logic       addrOk;
  assign effAddr = ioSpace ? 8'(ioAddr + `PWSC_IO_SPACE_BASE) : ioAddr;
  assign addrOk  = !ioSpace || (ioAddr <= `PWSC_IO_SPACE_LAST);
  logic wrSleepCtl, wrPctl, wrGate, wrConv, wrComp;
  assign wrSleepCtl = ioWrite && addrOk && effAddr == `PWSC_OFF_SLEEP_MODE_CONTROL;
  assign wrPctl = ioWrite && addrOk && effAddr == `PWSC_OFF_PROCESSOR_CONTROL;
  assign wrGate = ioWrite && addrOk && effAddr == `PWSC_OFF_PERIPH_CLOCK_GATING;
  assign wrConv = ioWrite && addrOk && effAddr == `PWSC_OFF_CONVERTER_IN_DISABLE;
  assign wrComp = ioWrite && addrOk && effAddr == `PWSC_OFF_COMPARATOR_IN_DISABLE;

  // --------------------------------------------------------------------------
  // plain control registers
  // --------------------------------------------------------------------------
  logic [3:0] sleepCtl;
  logic [7:0] gateBits;
  logic [7:0] convDisable;
  logic [1:0] compDisable;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sleepCtl    <= 4'(`PWSC_RST_SLEEP_MODE_CONTROL);
      gateBits    <= `PWSC_RST_PERIPH_CLOCK_GATING;
      convDisable <= `PWSC_RST_CONV_IN_DISABLE;
      compDisable <= 2'(`PWSC_RST_COMP_IN_DISABLE);
      pullupDisable <= 1'b0;
    end else begin
      if (wrSleepCtl)
        sleepCtl <= 4'(ioWrData & `PWSC_MASK_SLEEP_MODE_CONTROL);
      if (wrGate)
        gateBits <= ioWrData & `PWSC_MASK_PERIPH_CLOCK_GATING;
      if (wrConv)
        convDisable <= ioWrData;
      if (wrComp)
        compDisable <= 2'(ioWrData & `PWSC_MASK_COMP_IN_DISABLE);
      if (wrPctl)
        pullupDisable <= ioWrData[`PWSC_PULLUP_DIS_BIT];
    end
  end
  logic             sleepEnable;
  pwsc_sleep_mode_t modeSel;
  assign sleepEnable = sleepCtl[`PWSC_SLEEP_EN_BIT];
  assign modeSel     = pwsc_sleep_mode_t'(sleepCtl[`PWSC_MODE_MSB:`PWSC_MODE_LSB]);

  // --------------------------------------------------------------------------
  // detector sleep disable timed sequence
  // --------------------------------------------------------------------------
  logic       detArm;
  logic [2:0] armLeft;
  logic       detDis;
  logic [2:0] detAge;
  logic       armWrite, setWrite;
  assign armWrite = wrPctl && ioWrData[`PWSC_DET_DIS_BIT] && ioWrData[`PWSC_DET_ARM_BIT];
  assign setWrite = wrPctl && ioWrData[`PWSC_DET_DIS_BIT] && !ioWrData[`PWSC_DET_ARM_BIT];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      detArm  <= 1'b0;
      armLeft <= 3'd0;
    end else if (armWrite) begin
      detArm  <= 1'b1;
      armLeft <= `PWSC_ARM_WINDOW_CYCLES;
    end else if (setWrite || armLeft == 3'd1) begin
      detArm  <= 1'b0;
      armLeft <= 3'd0;
    end else if (armLeft != 3'd0) begin
      armLeft <= armLeft - 3'd1;
    end
  end
  // the bit sits pending for three cycles, then stays effective for three more
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      detDis <= 1'b0;
      detAge <= 3'd0;
    end else if (setWrite && detArm && !detDis) begin
      detDis <= 1'b1;
      detAge <= 3'd0;
    end else if (detDis) begin
      if (detAge == 3'(`PWSC_DET_DELAY_CYCLES + `PWSC_DET_ACTIVE_CYCLES - 3'd1)) begin
        detDis <= 1'b0;
        detAge <= 3'd0;
      end else begin
        detAge <= detAge + 3'd1;
      end
    end
  end
  assign detectorDisableEffective = detDis && detAge >= `PWSC_DET_DELAY_CYCLES;

  // --------------------------------------------------------------------------
  // vector select change sequence
  // --------------------------------------------------------------------------
  logic       vecChg;
  logic [2:0] vecChgLeft;
  logic       waitRetire;
  logic       selWrite;
  assign selWrite = wrPctl && vecChg && !ioWrData[`PWSC_VEC_CHG_BIT];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vecChg       <= 1'b0;
      vecChgLeft   <= 3'd0;
      vectorSelect <= 1'b0;
    end else if (wrPctl && ioWrData[`PWSC_VEC_CHG_BIT]) begin
      vecChg     <= 1'b1;
      vecChgLeft <= `PWSC_VEC_WINDOW_CYCLES;
    end else if (selWrite) begin
      vectorSelect <= ioWrData[`PWSC_VEC_SEL_BIT];
      vecChg       <= 1'b0;
      vecChgLeft   <= 3'd0;
    end else if (vecChg) begin
      vecChgLeft <= vecChgLeft - 3'd1;
      if (vecChgLeft == 3'd1)
        vecChg <= 1'b0;
    end
  end
  // after the select write, hold the block through the next retired instruction
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      waitRetire <= 1'b0;
    else if (selWrite)
      waitRetire <= 1'b1;
    else if (instrRetire)
      waitRetire <= 1'b0;
  end
  logic lockBlock;
  assign lockBlock = (vectorSelect && appLock && !execInBoot) ||
                     (!vectorSelect && bootLock && execInBoot);
  // a separate gate; the core's global enable flag is never written here
  assign irqBlock = vecChg || waitRetire || lockBlock;

  // --------------------------------------------------------------------------
  // sleep state
  // --------------------------------------------------------------------------
  pwsc_state_t state;
  logic        modeLegal;
  assign modeLegal = modeSel != PWSC_RSVD_A && modeSel != PWSC_RSVD_B;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state               <= PWSC_AWAKE;
      activeSleepMode     <= PWSC_IDLE;
      brownoutDetectorOff <= 1'b0;
    end else begin
      unique case (state)
        PWSC_AWAKE: begin
          // reserved codes are refused rather than guessed at
          if (sleepInstr && sleepEnable && modeLegal) begin
            state               <= PWSC_SLEEPING;
            activeSleepMode     <= modeSel;
            brownoutDetectorOff <= detectorDisableEffective;
          end
        end
        PWSC_SLEEPING: begin
          if (wakeEvent) begin
            state               <= PWSC_AWAKE;
            brownoutDetectorOff <= 1'b0;
          end
        end
      endcase
    end
  end
  assign sleeping = state == PWSC_SLEEPING;

  logic ioStop, adcStop;
  always_comb begin
    ioStop  = 1'b0;
    adcStop = 1'b0;
    if (sleeping) begin
      unique case (activeSleepMode)
        PWSC_IDLE: begin
          ioStop  = 1'b0;
          adcStop = 1'b0;
        end
        PWSC_NOISE_REDUCE: begin
          ioStop  = 1'b1;
          adcStop = 1'b0;
        end
        default: begin
          ioStop  = 1'b1;
          adcStop = 1'b1;
        end
      endcase
    end
  end
  assign ioClkRun  = !ioStop;
  assign adcClkRun = !adcStop;
  assign mainClkRun = !sleeping || debugOn || activeSleepMode == PWSC_IDLE ||
                      activeSleepMode == PWSC_NOISE_REDUCE || activeSleepMode == PWSC_STANDBY ||
                      activeSleepMode == PWSC_EXT_STANDBY;
  assign watchdogRun = wdogOn;

  // --------------------------------------------------------------------------
  // input buffers and clock gating
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : gPin
      assign pinInBufEn[gi] = !(ioStop && adcStop) || wakePinMask[gi];
    end
  endgenerate
  assign convInBufEn = ~convDisable & {8{!(ioStop && adcStop)}};
  assign compInBufEn = ~compDisable & {2{!(ioStop && adcStop)}};
  // a gated peripheral also refuses register access via this same enable
  assign periphClkEn   = ~gateBits;
  assign timerTwoClkEn = !(gateBits[`PWSC_GATE_TIMER_TWO_BIT] && !timerTwoAsyncSelect);

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ioRdData <= 8'h00;
    end else if (ioRead && addrOk) begin
      unique case (effAddr)
        `PWSC_OFF_SLEEP_MODE_CONTROL:    ioRdData <= {4'h0, sleepCtl};
        `PWSC_OFF_PROCESSOR_CONTROL:     ioRdData <= {1'b0, detDis, detArm, pullupDisable, 2'b00, vectorSelect, vecChg};
        `PWSC_OFF_PERIPH_CLOCK_GATING:   ioRdData <= gateBits;
        `PWSC_OFF_CONVERTER_IN_DISABLE:  ioRdData <= convDisable;
        `PWSC_OFF_COMPARATOR_IN_DISABLE: ioRdData <= {6'h00, compDisable};
        default:                         ioRdData <= 8'h00;
      endcase
    end else begin
      ioRdData <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sleep_needs_se_a: assert property (!sleeping && !sleepEnable |=> !sleeping)
    else $error("sleep entered without sleep enable");
  reserved_no_sleep_a: assert property (!sleeping && !modeLegal |=> !sleeping)
    else $error("sleep entered with reserved mode");
  det_timing_a: assert property ($rose(detDis) |-> !detectorDisableEffective [*3] ##1 detectorDisableEffective [*3] ##1 !detDis)
    else $error("detector disable timing wrong");
  det_no_arm_a: assert property (!detArm && !detDis |=> !detDis)
    else $error("detector disable set without arm");
  vec_chg_clear_a: assert property ($rose(vecChg) |-> ##[1:4] !vecChg)
    else $error("change enable not cleared in four cycles");
  vec_sel_guard_a: assert property (!vecChg |=> $stable(vectorSelect))
    else $error("vector select changed without enable");
  irq_block_a: assert property (wrPctl && ioWrData[`PWSC_VEC_CHG_BIT] |=> irqBlock)
    else $error("interrupts not blocked during change window");
  det_off_cause_a: assert property ($rose(brownoutDetectorOff) |-> $past(detectorDisableEffective))
    else $error("detector off without effective disable");
  buf_deep_a: assert property (sleeping && !ioClkRun && !adcClkRun && !wakePinMask[0] |-> !pinInBufEn[0])
    else $error("input buffer left on in deep sleep");
  timer2_async_a: assert property (timerTwoAsyncSelect |-> timerTwoClkEn)
    else $error("async timer two stopped by gating");
  main_clk_dbg_a: assert property (debugOn |-> mainClkRun)
    else $error("main clock stopped with debug on");

  cover_sleep_c: cover property (sleepInstr && sleepEnable && modeLegal ##1 sleeping);
  cover_det_sleep_c: cover property (sleepInstr && detectorDisableEffective && sleepEnable && modeLegal);
  cover_vector_select_c: cover property (selWrite ##1 waitRetire);
  cover_vec_timeout_c: cover property ($rose(vecChg) ##4 !vecChg);

endmodule

// ---- pwsc_core_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// processor side: register accesses and the sleep instruction
// ----------------------------------------------------------------------------
module pwsc_core_model (
  input  wire logic       ref_clk,
  output logic [7:0]      ioAddr,
  output logic            ioSpace,
  output logic            ioWrite,
  output logic            ioRead,
  output logic [7:0]      ioWrData,
  output logic            sleepInstr,
  output logic            instrRetire
);
  initial begin
    ioAddr = 8'h00;
    ioSpace = 1'b0;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioWrData = 8'h00;
    sleepInstr = 1'b0;
    instrRetire = 1'b0;
  end

  // one strobe cycle then one idle cycle, so no strobe toggles twice in a step
  task automatic access(input logic wr, input logic [7:0] addr, input logic sp, input logic [7:0] d);
    ioWrite = wr;
    ioRead = !wr;
    ioAddr = addr;
    ioSpace = sp;
    ioWrData = d;
    @(negedge ref_clk);
    ioWrite = 1'b0;
    ioRead = 1'b0;
    // released data bus must not look like the last value
    ioWrData = ~d;
    @(negedge ref_clk);
  endtask

  // enable is written right before the instruction and left set until wake clears it
  task automatic go_sleep(input logic [2:0] mode, input logic en);
    access(1'b1, 8'h53, 1'b0, {4'h0, mode, en});
    sleepInstr = 1'b1;
    @(negedge ref_clk);
    sleepInstr = 1'b0;
  endtask

  task automatic arm_detector();
    access(1'b1, 8'h55, 1'b0, 8'h60);
    access(1'b1, 8'h55, 1'b0, 8'h40);
  endtask

  task automatic move_vectors(input logic sel);
    access(1'b1, 8'h55, 1'b0, 8'h01);
    access(1'b1, 8'h55, 1'b0, {6'h00, sel, 1'b0});
  endtask

  task automatic retire();
    instrRetire = 1'b1;
    @(negedge ref_clk);
    instrRetire = 1'b0;
  endtask
endmodule

// ---- pwsc_power_sleep_control_regs_bench.sv ----
`timescale 1ns/1ps
module pwsc_power_sleep_control_regs_bench;
  import pwsc_pkg::*;
  localparam int PC = 23;
  logic ref_clk, resetn, ioSpace, ioWrite, ioRead, sleepInstr, wakeEvent, instrRetire, execInBoot;
  logic timerTwoAsyncSelect, debugEnableFuse, watchdogEnable, applicationBootLock, bootloaderBootLock;
  logic [7:0] ioAddr, ioWrData, ioRdData, periphClkEn, convInBufEn, d;
  logic sleeping, ioClkRun, adcClkRun, mainClkRun, watchdogRun, brownoutDetectorOff, timerTwoClkEn;
  logic detectorDisableEffective, pullupDisable, vectorSelect, irqBlock, rdPend;
  logic [1:0] compInBufEn;
  logic [2:0] m;
  logic [PC-1:0] wakePinMask, pinInBufEn, expBuf;
  pwsc_sleep_mode_t activeSleepMode;
  logic [7:0] rdq[$];
  int mismatches, checked, cycles, i;
  logic [31:0] seed;

  pwsc_power_sleep_control_regs #(.PIN_COUNT(PC)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr), .ioSpace(ioSpace), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .sleepInstr(sleepInstr),
    .wakeEvent(wakeEvent), .instrRetire(instrRetire), .execInBoot(execInBoot),
    .timerTwoAsyncSelect(timerTwoAsyncSelect), .debugEnableFuse(debugEnableFuse),
    .watchdogEnable(watchdogEnable), .applicationBootLock(applicationBootLock),
    .bootloaderBootLock(bootloaderBootLock), .wakePinMask(wakePinMask), .sleeping(sleeping),
    .activeSleepMode(activeSleepMode), .ioClkRun(ioClkRun), .adcClkRun(adcClkRun),
    .mainClkRun(mainClkRun), .watchdogRun(watchdogRun), .brownoutDetectorOff(brownoutDetectorOff),
    .detectorDisableEffective(detectorDisableEffective), .pullupDisable(pullupDisable),
    .vectorSelect(vectorSelect), .irqBlock(irqBlock), .periphClkEn(periphClkEn),
    .timerTwoClkEn(timerTwoClkEn), .pinInBufEn(pinInBufEn), .convInBufEn(convInBufEn),
    .compInBufEn(compInBufEn)
  );

  pwsc_core_model core (
    .ref_clk(ref_clk), .ioAddr(ioAddr), .ioSpace(ioSpace), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWrData(ioWrData), .sleepInstr(sleepInstr), .instrRetire(instrRetire)
  );

  // ----------------------------------------------------------------------------
  // checking and verdict
  // ----------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] addr, input logic sp, input logic [7:0] exp);
    rdq.push_back(exp);
    core.access(1'b0, addr, sp, 8'h00);
  endtask

  // wake the core, then software clears the enable at once
  task automatic wake();
    wakeEvent = 1'b1;
    @(negedge ref_clk);
    wakeEvent = 1'b0;
    chk("sleeping", 1'b0, sleeping);
    core.access(1'b1, 8'h53, 1'b0, 8'h00);
  endtask

  // read data stands for one cycle after the strobe edge
  always @(posedge ref_clk) rdPend <= ioRead;
  always @(negedge ref_clk) begin
    if (rdPend === 1'b1) begin
      chk("ioRdData", rdq.size() > 0 ? rdq.pop_front() : 8'hxx, ioRdData);
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // whole run is well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    seed = 32'hd1b5f5a6;
    resetn = 1'b0;
    wakeEvent = 1'b0;
    execInBoot = 1'b0;
    timerTwoAsyncSelect = 1'b0;
    debugEnableFuse = 1'b0;
    watchdogEnable = 1'b1;
    applicationBootLock = 1'b0;
    bootloaderBootLock = 1'b0;
    wakePinMask = PC'($random(seed));
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk("periphClkEn", 8'hff, periphClkEn);
    rd(8'h53, 1'b0, 8'h00);
    rd(8'h55, 1'b0, 8'h00);
    rd(8'h64, 1'b0, 8'h00);
    core.access(1'b1, 8'h33, 1'b1, 8'hff);
    rd(8'h53, 1'b0, 8'h0f);
    rd(8'h33, 1'b1, 8'h0f);
    core.access(1'b1, 8'h44, 1'b1, 8'hff);
    rd(8'h44, 1'b1, 8'h00);
    rd(8'h01, 1'b0, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      timerTwoAsyncSelect = i[0];
      core.access(1'b1, 8'h64, 1'b0, d);
      rd(8'h64, 1'b0, d & 8'hef);
      chk("periphClkEn", 8'(~(d & 8'hef)), periphClkEn);
      chk("timerTwoClkEn", !(d[6] && !i[0]), timerTwoClkEn);
    end
    core.access(1'b1, 8'h64, 1'b0, 8'h00);
    core.go_sleep(3'd2, 1'b0);
    chk("sleeping", 1'b0, sleeping);
    for (i = 0; i < 8; i++) begin
      m = i[2:0];
      core.go_sleep(m, 1'b1);
      chk("sleeping", m != 3'd4 && m != 3'd5, sleeping);
      if (m != 3'd4 && m != 3'd5) begin
        expBuf = m[1] ? wakePinMask : '1;
        chk("activeSleepMode", m, activeSleepMode);
        chk("ioClkRun", m == 3'd0, ioClkRun);
        chk("adcClkRun", !m[1], adcClkRun);
        chk("pinInBufEn", expBuf, pinInBufEn);
        chk("mainClkRun", m != 3'd2 && m != 3'd3, mainClkRun);
        chk("watchdogRun", 1'b1, watchdogRun);
        chk("brownoutDetectorOff", 1'b0, brownoutDetectorOff);
        wake();
      end
    end
    debugEnableFuse = 1'b1;
    watchdogEnable = 1'b0;
    repeat (3) @(negedge ref_clk);
    core.go_sleep(3'd2, 1'b1);
    chk("mainClkRun", 1'b1, mainClkRun);
    chk("watchdogRun", 1'b0, watchdogRun);
    wake();
    core.access(1'b1, 8'h55, 1'b0, 8'h40);
    chk("detectorDisableEffective", 1'b0, detectorDisableEffective);
    core.access(1'b1, 8'h55, 1'b0, 8'h60);
    repeat (4) @(negedge ref_clk);
    core.access(1'b1, 8'h55, 1'b0, 8'h40);
    repeat (4) @(negedge ref_clk);
    chk("detectorDisableEffective", 1'b0, detectorDisableEffective);
    core.arm_detector();
    chk("detectorDisableEffective", 1'b0, detectorDisableEffective);
    core.go_sleep(3'd2, 1'b1);
    chk("brownoutDetectorOff", 1'b1, brownoutDetectorOff);
    wake();
    chk("detectorDisableEffective", 1'b0, detectorDisableEffective);
    rd(8'h55, 1'b0, 8'h00);
    core.access(1'b1, 8'h55, 1'b0, 8'h01);
    chk("irqBlock", 1'b1, irqBlock);
    repeat (4) @(negedge ref_clk);
    chk("irqBlock", 1'b0, irqBlock);
    rd(8'h55, 1'b0, 8'h00);
    core.move_vectors(1'b1);
    chk("vectorSelect", 1'b1, vectorSelect);
    chk("irqBlock", 1'b1, irqBlock);
    core.retire();
    chk("irqBlock", 1'b0, irqBlock);
    core.access(1'b1, 8'h55, 1'b0, 8'h10);
    chk("vectorSelect", 1'b1, vectorSelect);
    chk("pullupDisable", 1'b1, pullupDisable);
    rd(8'h35, 1'b1, 8'h12);
    applicationBootLock = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("irqBlock", 1'b1, irqBlock);
    execInBoot = 1'b1;
    @(negedge ref_clk);
    chk("irqBlock", 1'b0, irqBlock);
    d = 8'($random(seed));
    core.access(1'b1, 8'h7e, 1'b0, d);
    chk("convInBufEn", 8'(~d), convInBufEn);
    core.access(1'b1, 8'h7f, 1'b0, d);
    chk("compInBufEn", 2'(~d[1:0]), compInBufEn);
    print_verdict();
  end
endmodule
